// >>> hw/isr_consts.vh
// Constants for the serial register access slave.
`ifndef ISR_CONSTS_VH
`define ISR_CONSTS_VH

// ------------------------------------------------------------
// Mode strap and bus addressing
// ------------------------------------------------------------
`define ISR_MODE_I2C 2'h2
`define ISR_MODE_RST 2'h0
`define ISR_SLAVE_ADDR 7'h0A
`define ISR_IDX_RST 8'h00

// ------------------------------------------------------------
// Field positions and counts
// ------------------------------------------------------------
`define ISR_RW_BIT 0
`define ISR_LAST_BIT 3'h7
`define ISR_LAST_BYTE 2'h3
`define ISR_LINES_IDLE 2'h3

`endif

// >>> hw/isr_i2c_slave.v
// Serial two-wire slave giving a host access to 32-bit registers.
`default_nettype none
`include "isr_consts.vh"

module isr_i2c_slave (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Management mode strap
    input wire [1:0] mgmt_mode_strap,
    // Bus lines, open drain data
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    // Register access port
    output wire [9:0] reg_rd_addr,
    input wire [31:0] reg_rd_data,
    input wire reg_rd_hit,
    output reg [9:0] reg_done_addr,
    output reg reg_rd_done,
    output reg reg_wr_en,
    output reg [31:0] reg_wr_data,
    // Status
    output wire mgmt_en
);

// ------------------------------------------------------------
// States
// ------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;  // Ignore bus until a start
localparam [2:0] ST_CTRL = 3'h1;  // Receive control byte
localparam [2:0] ST_RADDR = 3'h2; // Receive register index
localparam [2:0] ST_WDATA = 3'h3; // Receive write data
localparam [2:0] ST_ACK = 3'h4;   // Drive our acknowledge
localparam [2:0] ST_RDATA = 3'h5; // Shift out read data
localparam [2:0] ST_MACK = 3'h6;  // Sample master acknowledge

// ------------------------------------------------------------
// Declarations
// ------------------------------------------------------------
reg [1:0] strap_reg;      // Captured strap value
reg strap_seen_reg;       // Strap caught after reset
reg [1:0] strap_sync1_reg; // First strap sync stage
reg [1:0] strap_sync2_reg; // Second strap sync stage
reg [1:0] sync1_reg;      // First sync stage {scl,sda}
reg [1:0] sync2_reg;      // Second sync stage
reg [1:0] samp_reg;       // Extra sample for filter
reg [1:0] samp2_reg;      // Second extra sample
reg [1:0] filt_reg;       // Filtered lines
reg [1:0] prev_reg;       // Filtered lines last cycle
reg [2:0] state_reg;      // Protocol state
reg [2:0] ack_next_reg;   // State after our acknowledge
reg [2:0] bit_cnt_reg;    // Bit within byte
reg byte_done_reg;        // Eight bits seen
reg [1:0] byte_cnt_reg;   // Byte within DWORD
reg rw_reg;               // Read when high
reg [7:0] shift_reg;      // Receive shifter
reg [23:0] wbuf_reg;      // First three write bytes
reg [31:0] tx_reg;        // Read snapshot shifter
reg [7:0] idx_reg;        // Internal DWORD index
reg multi_reg;            // A fourth byte was acked this read
wire scl_f;
wire sda_f;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire [31:0] rd_value;

// ------------------------------------------------------------
// Strap capture and enable
// ------------------------------------------------------------
// Strap pin is asynchronous: two flops before anything reads it
// No reset here, so the pipe is already full when reset lifts
always @(posedge clk) begin
    strap_sync1_reg <= mgmt_mode_strap;
    strap_sync2_reg <= strap_sync1_reg;
end

// Catch the strap on the first edge after reset release
always @(posedge clk) begin
    if (!rst_n) begin
        strap_reg <= `ISR_MODE_RST;
        strap_seen_reg <= 1'b0;
    end else if (!strap_seen_reg) begin
        // Strap must be steady for two cycles before release
        strap_reg <= strap_sync2_reg;
        strap_seen_reg <= 1'b1;
    end
end

// Slave only runs in the managed mode
assign mgmt_en = strap_seen_reg && (strap_reg == `ISR_MODE_I2C);

// ------------------------------------------------------------
// Line synchroniser and glitch filter
// ------------------------------------------------------------
// Two flops, then a high must hold three samples to pass; a low passes at once
always @(posedge clk) begin
    if (!rst_n) begin
        sync1_reg <= `ISR_LINES_IDLE;
        sync2_reg <= `ISR_LINES_IDLE;
        samp_reg <= `ISR_LINES_IDLE;
        samp2_reg <= `ISR_LINES_IDLE;
        filt_reg <= `ISR_LINES_IDLE;
        prev_reg <= `ISR_LINES_IDLE;
    end else begin
        sync1_reg <= {scl_in, sda_in};
        sync2_reg <= sync1_reg;
        samp_reg <= sync2_reg;
        samp2_reg <= samp_reg;
        // Set bits high over three samples, clear bits whose samples differ
        filt_reg <= (filt_reg & ~(sync2_reg ^ samp_reg)
                     & ~(samp_reg ^ samp2_reg))
                    | (sync2_reg & samp_reg & samp2_reg);
        prev_reg <= filt_reg;
    end
end

// Filter delay is tens of ns, far under a 400 kHz bit time
assign scl_f = filt_reg[1];
assign sda_f = filt_reg[0];
assign scl_rise = scl_f && !prev_reg[1];
assign scl_fall = !scl_f && prev_reg[1];
// Data moving while clock stays high marks start or stop
assign start_det = scl_f && prev_reg[1] && !sda_f && prev_reg[0];
assign stop_det = scl_f && prev_reg[1] && sda_f && !prev_reg[0];

// ------------------------------------------------------------
// Register port
// ------------------------------------------------------------
// Index with two zero bits appended gives byte address
assign reg_rd_addr = {idx_reg, 2'b00};
// Unused addresses read as zero
assign rd_value = reg_rd_hit ? reg_rd_data : 32'h0000_0000;
// Open drain: only ever pull low
assign sda_out = 1'b0;

// ------------------------------------------------------------
// Protocol engine
// ------------------------------------------------------------
// Bits sampled on clock rise, driven on clock fall
always @(posedge clk) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
        ack_next_reg <= ST_IDLE;
        bit_cnt_reg <= 3'h0;
        byte_done_reg <= 1'b0;
        byte_cnt_reg <= 2'h0;
        rw_reg <= 1'b0;
        shift_reg <= 8'h00;
        wbuf_reg <= 24'h00_0000;
        tx_reg <= 32'h0000_0000;
        idx_reg <= `ISR_IDX_RST;
        multi_reg <= 1'b0;
        sda_oe <= 1'b0;
        reg_done_addr <= 10'h000;
        reg_rd_done <= 1'b0;
        reg_wr_en <= 1'b0;
        reg_wr_data <= 32'h0000_0000;
    end else begin
        reg_rd_done <= 1'b0;
        reg_wr_en <= 1'b0;
        if (!mgmt_en) begin
            // Interface disabled: stay off the bus
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start_det || stop_det) begin
            // Abandon any transfer and release data at once
            state_reg <= start_det ? ST_CTRL : ST_IDLE;
            sda_oe <= 1'b0;
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            byte_cnt_reg <= 2'h0;
            // New sequence forgets any earlier multiple read
            multi_reg <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                ST_CTRL, ST_RADDR, ST_WDATA, ST_RDATA: begin
                    // Msb first into the shifter
                    shift_reg <= {shift_reg[6:0], sda_f};
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    byte_done_reg <= (bit_cnt_reg == `ISR_LAST_BIT);
                end
                ST_MACK: begin
                    if (byte_cnt_reg == `ISR_LAST_BYTE) begin
                        // Whole DWORD sent: side effect now
                        reg_rd_done <= 1'b1;
                        reg_done_addr <= {idx_reg, 2'b00};
                        // Ack on fourth byte moves on, wraps at top
                        if (!sda_f) begin
                            idx_reg <= idx_reg + 8'h01;
                            multi_reg <= 1'b1;
                        end else if (multi_reg) begin
                            // Final register of a multiple read counts too
                            idx_reg <= idx_reg + 8'h01;
                        end else begin
                            // Lone register read: index stays put
                            idx_reg <= idx_reg;
                        end
                    end
                    if (sda_f) begin
                        // Nak: send nothing more this sequence
                        state_reg <= ST_IDLE;
                    end
                    // Four bytes per register on the wire
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
                default: begin
                    // Idle and acknowledge ignore clock rise
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_CTRL: begin
                    if (byte_done_reg) begin
                        byte_done_reg <= 1'b0;
                        if (shift_reg[7:1] == `ISR_SLAVE_ADDR) begin
                            // Address matches: acknowledge
                            state_reg <= ST_ACK;
                            sda_oe <= 1'b1;
                            rw_reg <= shift_reg[`ISR_RW_BIT];
                            ack_next_reg <= shift_reg[`ISR_RW_BIT]
                                            ? ST_RDATA : ST_RADDR;
                        end else begin
                            // Not ours: wait for next start
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RADDR: begin
                    if (byte_done_reg) begin
                        // Index loaded now, kept if a start/stop follows
                        byte_done_reg <= 1'b0;
                        idx_reg <= shift_reg;
                        state_reg <= ST_ACK;
                        sda_oe <= 1'b1;
                        ack_next_reg <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (byte_done_reg) begin
                        // Every write byte is acknowledged
                        byte_done_reg <= 1'b0;
                        state_reg <= ST_ACK;
                        sda_oe <= 1'b1;
                        ack_next_reg <= ST_WDATA;
                        wbuf_reg <= {wbuf_reg[15:0], shift_reg};
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                        if (byte_cnt_reg == `ISR_LAST_BYTE) begin
                            // Commit only a full 32-bit word
                            reg_wr_en <= 1'b1;
                            reg_wr_data <= {wbuf_reg, shift_reg};
                            reg_done_addr <= {idx_reg, 2'b00};
                            idx_reg <= idx_reg + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    // Release acknowledge, continue per direction
                    state_reg <= ack_next_reg;
                    bit_cnt_reg <= 3'h0;
                    sda_oe <= 1'b0;
                    // Only a read control byte leads straight into data
                    if (rw_reg) begin
                        // Read starts right after control ack
                        tx_reg <= {rd_value[30:0], 1'b0};
                        sda_oe <= !rd_value[31];
                    end
                end
                ST_RDATA: begin
                    if (byte_done_reg) begin
                        // Byte out: release for master acknowledge
                        byte_done_reg <= 1'b0;
                        state_reg <= ST_MACK;
                        sda_oe <= 1'b0;
                    end else begin
                        tx_reg <= {tx_reg[30:0], 1'b0};
                        sda_oe <= !tx_reg[31];
                    end
                end
                ST_MACK: begin
                    // Acked: next byte, fresh snapshot per DWORD
                    state_reg <= ST_RDATA;
                    bit_cnt_reg <= 3'h0;
                    if (byte_cnt_reg == 2'h0) begin
                        tx_reg <= {rd_value[30:0], 1'b0};
                        sda_oe <= !rd_value[31];
                    end else begin
                        tx_reg <= {tx_reg[30:0], 1'b0};
                        sda_oe <= !tx_reg[31];
                    end
                end
                default: begin
                    // Idle ignores clock fall
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // isr_i2c_slave
`default_nettype wire

// >>> verif/isr_i2c_slave_assertions.sv
// Checker on the ports of the two-wire register slave.
`default_nettype none
module isr_i2c_slave_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Strap and enable
    input wire logic [1:0] mgmt_mode_strap,
    input wire logic mgmt_en,
    // Bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Register port
    input wire logic [9:0] reg_rd_addr,
    input wire logic [31:0] reg_rd_data,
    input wire logic reg_rd_hit,
    input wire logic [9:0] reg_done_addr,
    input wire logic reg_rd_done,
    input wire logic reg_wr_en,
    input wire logic [31:0] reg_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Disabled slave stays off the bus and the register port
    property p_off;
        !mgmt_en |-> !sda_oe && !reg_wr_en && !reg_rd_done;
    endproperty
    a_off: assert property (p_off) else $error("off slave active");
    // Enable follows the strap once captured
    property p_strap;
        $past(rst_n) && $past(rst_n, 2)
            |-> mgmt_en == (mgmt_mode_strap == 2'h2);
    endproperty
    a_strap: assert property (p_strap) else $error("enable vs strap");
    // Data driver only switches on while the clock line is low
    property p_oe_rise;
        $rose(sda_oe) |-> !scl_in;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("drive in high");
    // Stop leaves the data line released
    property p_stop;
        scl_in && $rose(sda_in) |=> (!sda_oe) [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
    // Commit is a single-cycle pulse
    property p_wr_pulse;
        reg_wr_en |=> !reg_wr_en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("long write");
    // Read-complete is a single-cycle pulse
    property p_rd_pulse;
        reg_rd_done |=> !reg_rd_done;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("long rd done");
    // Index moves one DWORD past each committed write
    property p_wr_inc;
        reg_wr_en |=> reg_rd_addr == reg_done_addr + 10'h004;
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("no increment");
    // Byte addresses are DWORD aligned
    property p_align;
        reg_rd_addr[1:0] == 2'h0 && reg_done_addr[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align) else $error("unaligned");
    // Write data moves only with a commit
    property p_wr_hold;
        !reg_wr_en |-> $stable(reg_wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("data moved");
    c_wr: cover property (reg_wr_en);
    c_rd: cover property (reg_rd_done);
    c_ack: cover property ($rose(sda_oe));
endmodule // isr_i2c_slave_chk
bind isr_i2c_slave isr_i2c_slave_chk u_chk (.clk(clk), .rst_n(rst_n),
    .mgmt_mode_strap(mgmt_mode_strap), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit),
    .reg_done_addr(reg_done_addr), .reg_rd_done(reg_rd_done),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .mgmt_en(mgmt_en));
`default_nettype wire

// >>> verif/isr_bus_master.sv
// Bus master model pacing the link from the system clock.
`default_nettype none
module isr_bus_master (
    // Pacing clock
    input wire logic clk,
    // Link lines, data seen as wired level
    output var logic scl,
    output var logic sda_m,
    input wire logic sda_w
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0; // Extra low time after a byte
    // Lines idle high, clock stands still
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Wait falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start (b=1) or stop (b=0): data moves while clock high
    task automatic cond(input logic b);
        tick(4);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_m = ~b;
        tick(8);
        scl = ~b;
    endtask
    // One bit, 160 ns period, sampled late in the high phase
    task automatic bitx(input logic b, output logic r);
        tick(4);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(6);
        r = sda_w;
        tick(2);
        scl = 1'b0;
    endtask
    // Byte msb first plus acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ai,
                        output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ai, ao);
        tick(gap);
    endtask
endmodule // isr_bus_master
`default_nettype wire

// >>> verif/test_isr_i2c_slave.sv
// Self-checking bench for the two-wire register slave.
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
fail_count++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module test_isr_i2c_slave;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, scl, sda_m, oe, so, hit, rdd, wen, men, a;
    logic [1:0] strap;
    logic [9:0] ra, da;
    logic [31:0] rdat, wdat;
    logic [31:0] mem [256]; // Register file
    logic [31:0] ref_mem [256]; // Expected contents
    logic [7:0] cur, q, idx;
    int seed, n, fail_count = 0, cmp_count = 0;
    wire sda_w = sda_m & (oe ? so : 1'b1); // Pull-up, wired AND
    assign rdat = mem[ra[9:2]];
    assign hit = ra[9:2] != 8'h80; // One unused slot
    isr_i2c_slave dut (.clk(clk), .rst_n(rst_n), .mgmt_mode_strap(strap),
        .scl_in(scl), .sda_in(sda_w), .sda_out(so), .sda_oe(oe),
        .reg_rd_addr(ra), .reg_rd_data(rdat), .reg_rd_hit(hit),
        .reg_done_addr(da), .reg_rd_done(rdd), .reg_wr_en(wen),
        .reg_wr_data(wdat), .mgmt_en(men));
    isr_bus_master m (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
    // Commit writes; slot 40 clears on a completed read
    always @(posedge clk) begin
        if (wen)
            mem[da[9:2]] <= wdat;
        else if (rdd && da == 10'h100)
            mem[8'h40] <= 32'h0;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic reset(input logic [1:0] s);
        @(negedge clk);
        rst_n = 1'b0;
        strap = s;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (12) @(negedge clk);
    endtask
    // Start plus control byte, check the acknowledge
    task automatic ctrl(input logic [7:0] c, input logic ea);
        m.cond(1'b1);
        m.xfer(c, 1'b1, q, a);
        `CHK("ctrl_ack", ea, a)
    endtask
    // Load the index, no stop
    task automatic set(input logic [7:0] i);
        ctrl(8'h14, 1'b0);
        m.xfer(i, 1'b1, q, a);
        `CHK("idx_ack", 1'b0, a)
        cur = i;
    endtask
    task automatic wr(input logic [7:0] i, input int nb);
        logic [31:0] d;
        set(i);
        for (int b = 0; b < nb; b++) begin
            if (b % 4 == 0)
                d = $random(seed);
            m.xfer(d[8*(3-b%4) +: 8], 1'b1, q, a);
            `CHK("wr_ack", 1'b0, a)
            if (b % 4 == 3) begin
                ref_mem[cur] = d;
                cur++;
            end
        end
        m.cond(1'b0);
    endtask
    // Read nb bytes from the current index, nak the last
    task automatic rd(input int nb);
        logic [31:0] e;
        ctrl(8'h15, 1'b0);
        for (int b = 0; b < nb; b++) begin
            e = (cur == 8'h80) ? 32'h0 : ref_mem[cur];
            m.xfer(8'hFF, b == nb - 1, q, a);
            `CHK("rd_byte", e[8*(3-b%4) +: 8], q)
            if (b % 4 == 3) begin
                if (cur == 8'h40)
                    ref_mem[cur] = 32'h0;
                if (b != nb - 1 || nb > 4)
                    cur++;
            end
        end
        m.cond(1'b0);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        strap = 2'h1;
        seed = 32'hDA2E;
        for (int i = 0; i < 256; i++) begin
            mem[i] = $random(seed);
            ref_mem[i] = mem[i];
        end
        reset(2'h1);
        `CHK("mgmt_en", 1'b0, men)
        ctrl(8'h14, 1'b1);
        m.cond(1'b0);
        reset(2'h2);
        `CHK("mgmt_en", 1'b1, men)
        set(8'h00);
        rd(4);
        rd(4);
        for (int k = 1; k < 8; k++) begin
            ctrl(8'h14 ^ (8'h01 << k), 1'b1);
            m.xfer(8'h00, 1'b1, q, a);
            `CHK("ignored", 1'b1, a)
            m.cond(1'b0);
        end
        wr(8'hFE, 12);
        rd(4);
        set(8'hFE);
        rd(12);
        rd(4);
        wr(8'h20, 6);
        set(8'h20);
        rd(8);
        set(8'h80);
        rd(4);
        set(8'h40);
        rd(2);
        for (int k = 0; k < 3; k++) begin
            set(8'h40);
            rd(4);
        end
        for (int k = 0; k < 10; k++) begin
            m.gap = $random(seed) & 7;
            idx = $random(seed) & 8'h7C;
            n = 4 + ($random(seed) & 7);
            wr(idx, n);
            set(idx);
            rd(8);
        end
        finish_test;
    end
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        finish_test;
    end
endmodule // test_isr_i2c_slave
`default_nettype wire
